// ==== hdl/dual_edge_pwm_timer.sv ====
// Purpose: 32-bit timer with seven matches, four captures, six pwm outputs
// Assumes: one clock, synchronous active high reset, classic wishbone
// Notes:   capture pins pass a three stage synchroniser
//
// Implementation choices: the Wishbone slave port and the address map.
module dual_edge_pwm_timer (
  input  wire logic                                 core_clk,
  input  wire logic                                 reset,
  input  wire logic                                 wb_cyc_i,
  input  wire logic                                 wb_stb_i,
  input  wire logic                                 wb_we_i,
  input  wire logic [pwm_timer_pkg::ADR_W-1:0]      wb_adr_i,
  input  wire logic [3:0]                           wb_sel_i,
  input  wire logic [pwm_timer_pkg::DATA_W-1:0]     wb_dat_i,
  output logic      [pwm_timer_pkg::DATA_W-1:0]     wb_dat_o,
  output logic                                      wb_ack_o,
  input  wire logic [pwm_timer_pkg::NUM_CAP-1:0]    cap_in,
  output logic      [pwm_timer_pkg::NUM_PWM-1:0]    pwm_out
);
  import pwm_timer_pkg::*;

  typedef struct packed {
    logic                                ack;
    logic [DATA_W-1:0]                   rdata;
    logic [CTRL_W-1:0]                   ctrl;
    logic [NUM_FLAGS-1:0]                flags;
    logic [DATA_W-1:0]                   tc;
    logic [DATA_W-1:0]                   pr;
    logic [DATA_W-1:0]                   pc;
    logic [NUM_MATCH*MCR_W-1:0]          mcr;
    logic [NUM_CAP*CCR_W-1:0]            ccr;
    logic [PCR_W-1:0]                    pcr;
    logic [NUM_MATCH-1:0]                latch;
    logic [NUM_MATCH-1:0][DATA_W-1:0]    msh;
    logic [NUM_MATCH-1:0][DATA_W-1:0]    mact;
    logic [NUM_CAP-1:0][DATA_W-1:0]      cap;
    logic [NUM_CAP-1:0]                  s1;
    logic [NUM_CAP-1:0]                  s2;
    logic [NUM_CAP-1:0]                  s3;
    logic [NUM_CAP-1:0]                  filt;
    logic [NUM_PWM-1:0]                  pwm;
  } state_t;

  state_t st;
  state_t next_st;

  // byte lane merge of a write
  function automatic logic [DATA_W-1:0] merge(
    input logic [DATA_W-1:0] old_v,
    input logic [DATA_W-1:0] new_v,
    input logic [3:0]        sel
  );
    logic [DATA_W-1:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic                 run;
    logic                 inc;
    logic                 tick;
    logic                 pwm_on;
    logic                 acc;
    logic                 wr;
    logic                 load;
    logic                 set_o;
    logic                 clr_o;
    logic [NUM_CAP-1:0]   nf;
    logic [NUM_CAP-1:0]   rise;
    logic [NUM_CAP-1:0]   fall;
    logic [NUM_CAP-1:0]   cev;
    logic [NUM_MATCH-1:0] hit;
    logic [NUM_MATCH-1:0] rel;
    logic [NUM_FLAGS-1:0] fset;
    logic [NUM_FLAGS-1:0] fclr;
    logic [DATA_W-1:0]    rd;
    logic [DATA_W-1:0]    wv;
    run    = 1'b0;
    inc    = 1'b0;
    tick   = 1'b0;
    pwm_on = 1'b0;
    acc    = 1'b0;
    wr     = 1'b0;
    load   = 1'b0;
    set_o  = 1'b0;
    clr_o  = 1'b0;
    nf     = '0;
    rise   = '0;
    fall   = '0;
    cev    = '0;
    hit    = '0;
    rel    = '0;
    fset   = '0;
    fclr   = '0;
    rd     = '0;
    wv     = '0;
    next_st = st;

    // capture pin synchroniser and edge finder
    next_st.s1 = cap_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < NUM_CAP; i++) begin
      nf[i] = (st.s2[i] == st.s3[i]) ? st.s3[i] : st.filt[i];
    end
    next_st.filt = nf;
    rise = nf & ~st.filt;
    fall = ~nf & st.filt;

    // captures
    for (int i = 0; i < NUM_CAP; i++) begin
      cev[i] = (rise[i] & st.ccr[i*CCR_W + CCR_RISE])
             | (fall[i] & st.ccr[i*CCR_W + CCR_FALL]);
      if (cev[i]) begin
        next_st.cap[i] = st.tc;
      end
      fset[FLAG_CAP + i] = cev[i] & st.ccr[i*CCR_W + CCR_INT];
    end

    ////////////////////////////////////////////////////////////////////////
    // prescaler and counter
    pwm_on = st.ctrl[CTRL_PWM];
    run    = st.ctrl[CTRL_EN] & ~st.ctrl[CTRL_CLR];
    // external clock: one count per synchronised rising edge
    inc    = st.ctrl[CTRL_EXT] ? rise[st.ctrl[CTRL_CSEL +: 2]] : 1'b1;
    tick   = run & inc & (st.pc == st.pr);
    if (run & inc) begin
      next_st.pc = tick ? '0 : st.pc + 32'h0000_0001;
    end
    if (tick) begin
      next_st.tc = st.tc + 32'h0000_0001;
    end
    for (int i = 0; i < NUM_MATCH; i++) begin
      hit[i]  = tick & (st.tc == st.mact[i]);
      fset[i] = hit[i] & st.mcr[i*MCR_W + MCR_INT];
      if (hit[i] & (st.mcr[i*MCR_W + MCR_RST] | (i == 0 && pwm_on))) begin
        next_st.tc = '0;
      end
      if (hit[i] & st.mcr[i*MCR_W + MCR_STOP]) begin
        next_st.ctrl[CTRL_EN] = 1'b0;
      end
    end
    if (st.ctrl[CTRL_CLR]) begin
      next_st.tc = '0;
      next_st.pc = '0;
    end

    // released values enter the comparators at the period match
    load = pwm_on & hit[0];
    if (load) begin
      for (int i = 0; i < NUM_MATCH; i++) begin
        if (st.latch[i]) begin
          next_st.mact[i] = st.msh[i];
        end
      end
      next_st.latch = '0;
    end

    ////////////////////////////////////////////////////////////////////////
    // pwm outputs: output k falls on match k+1
    for (int k = 0; k < NUM_PWM; k++) begin
      if (st.pcr[k]) begin
        set_o = hit[k];
      end else begin
        set_o = hit[0] & (st.mact[k+1] != '0);
      end
      clr_o = hit[k+1];
      if (clr_o) begin
        next_st.pwm[k] = 1'b0;
      end else if (set_o) begin
        next_st.pwm[k] = 1'b1;
      end
      if (!(pwm_on & st.pcr[PCR_OE + k])) begin
        next_st.pwm[k] = 1'b0;
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // wishbone slave: one wait state, ack for one cycle
    acc = wb_cyc_i & wb_stb_i & ~st.ack;
    wr  = acc & wb_we_i;
    next_st.ack = acc;
    if (wb_adr_i == OFF_CTRL) begin
      rd = DATA_W'(st.ctrl);
      wv = merge(rd, wb_dat_i, wb_sel_i);
      if (wr) begin
        next_st.ctrl = wv[CTRL_W-1:0];
      end
    end else if (wb_adr_i == OFF_FLAGS) begin
      rd = DATA_W'(st.flags);
      wv = merge('0, wb_dat_i, wb_sel_i);
      if (wr) begin
        fclr = wv[NUM_FLAGS-1:0];
      end
    end else if (wb_adr_i == OFF_COUNT) begin
      rd = st.tc;
      if (wr) begin
        next_st.tc = merge(st.tc, wb_dat_i, wb_sel_i);
      end
    end else if (wb_adr_i == OFF_PRESCALE) begin
      rd = st.pr;
      if (wr) begin
        next_st.pr = merge(st.pr, wb_dat_i, wb_sel_i);
      end
    end else if (wb_adr_i == OFF_PRECOUNT) begin
      rd = st.pc;
      if (wr) begin
        next_st.pc = merge(st.pc, wb_dat_i, wb_sel_i);
      end
    end else if (wb_adr_i == OFF_MATCHCTL) begin
      rd = DATA_W'(st.mcr);
      wv = merge(rd, wb_dat_i, wb_sel_i);
      if (wr) begin
        next_st.mcr = wv[NUM_MATCH*MCR_W-1:0];
      end
    end else if (wb_adr_i == OFF_CAPCTL) begin
      rd = DATA_W'(st.ccr);
      wv = merge(rd, wb_dat_i, wb_sel_i);
      if (wr) begin
        next_st.ccr = wv[NUM_CAP*CCR_W-1:0];
      end
    end else if (wb_adr_i == OFF_PWMCTL) begin
      rd = DATA_W'(st.pcr);
      wv = merge(rd, wb_dat_i, wb_sel_i);
      if (wr) begin
        next_st.pcr = wv[PCR_W-1:0];
      end
    end else if (wb_adr_i == OFF_RELEASE) begin
      rd = DATA_W'(st.latch);
      wv = merge('0, wb_dat_i, wb_sel_i);
      if (wr) begin
        rel = wv[NUM_MATCH-1:0];
      end
    end else begin
      for (int i = 0; i < NUM_MATCH; i++) begin
        if (wb_adr_i == OFF_MATCH + ADR_W'(4 * i)) begin
          rd = st.msh[i];
          if (wr) begin
            next_st.msh[i] = merge(st.msh[i], wb_dat_i, wb_sel_i);
            // plain timer: no shadowing, value acts at once
            if (!pwm_on) begin
              next_st.mact[i] = merge(st.msh[i], wb_dat_i, wb_sel_i);
            end
          end
        end
      end
      for (int i = 0; i < NUM_CAP; i++) begin
        if (wb_adr_i == OFF_CAPTURE + ADR_W'(4 * i)) begin
          rd = st.cap[i];
        end
      end
    end
    if (acc) begin
      next_st.rdata = rd;
    end

    // new events win over a clear in the same cycle
    next_st.flags = (st.flags & ~fclr) | fset;
    next_st.latch = next_st.latch | rel;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st       <= '0;
      st.ctrl  <= CTRL_RESET;
      st.tc    <= COUNT_RESET;
      st.pr    <= PRE_RESET;
      st.pc    <= PRE_RESET;
      st.mcr   <= MCR_RESET;
      st.ccr   <= CCR_RESET;
      st.pcr   <= PCR_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign wb_dat_o = st.rdata;
  assign wb_ack_o = st.ack;
  assign pwm_out  = st.pwm;
endmodule // dual_edge_pwm_timer

// ==== hdl/pwm_timer_pkg.sv ====
// Purpose: constants for the dual edge pwm timer
// Assumes: 32-bit classic wishbone slave, byte addresses
// Notes:   match i at OFF_MATCH + 4*i, capture i at OFF_CAPTURE + 4*i
// Functional notes
// - prescaler of 32 bits feeds a 32-bit counter, the common time base
// - seven match registers compared against the counter give match events
// - four capture inputs store the counter on a chosen edge, optional flag
// - per match: optional flag, plus continue, stop or reset the counter
// - in pwm mode the period match restarts the count from zero
// - single edge outputs rise on period match, fall on own match
// - each extra single edge output uses one more match register
// - double edge output rises on one match, falls on the next
// - each extra double edge output uses two more match registers
// - six single, three double, or any mix within seven matches
// - period and width in whole counts, one rate for all outputs
// - software releases new match values; applied in step with pulses
// - without pwm mode the block is a plain timer, outputs stay low
// - external count clock on a capture input, at most a quarter rate
package pwm_timer_pkg;
  localparam int ADR_W     = 8;
  localparam int DATA_W    = 32;
  localparam int NUM_MATCH = 7;
  localparam int NUM_CAP   = 4;
  localparam int NUM_PWM   = 6;
  localparam int NUM_FLAGS = NUM_MATCH + NUM_CAP;

  localparam logic [ADR_W-1:0] OFF_CTRL     = 8'h00;
  localparam logic [ADR_W-1:0] OFF_FLAGS    = 8'h04;
  localparam logic [ADR_W-1:0] OFF_COUNT    = 8'h08;
  localparam logic [ADR_W-1:0] OFF_PRESCALE = 8'h0C;
  localparam logic [ADR_W-1:0] OFF_PRECOUNT = 8'h10;
  localparam logic [ADR_W-1:0] OFF_MATCHCTL = 8'h14;
  localparam logic [ADR_W-1:0] OFF_CAPCTL   = 8'h18;
  localparam logic [ADR_W-1:0] OFF_PWMCTL   = 8'h1C;
  localparam logic [ADR_W-1:0] OFF_RELEASE  = 8'h20;
  localparam logic [ADR_W-1:0] OFF_MATCH    = 8'h40;
  localparam logic [ADR_W-1:0] OFF_CAPTURE  = 8'h60;

  // control register fields
  localparam int CTRL_W     = 6;
  localparam int CTRL_EN    = 0;
  localparam int CTRL_CLR   = 1;
  localparam int CTRL_PWM   = 2;
  localparam int CTRL_EXT   = 3;
  localparam int CTRL_CSEL  = 4;
  // per match: 3 bits at 3*i
  localparam int MCR_W      = 3;
  localparam int MCR_INT    = 0;
  localparam int MCR_RST    = 1;
  localparam int MCR_STOP   = 2;
  // per capture: 3 bits at 3*i
  localparam int CCR_W      = 3;
  localparam int CCR_RISE   = 0;
  localparam int CCR_FALL   = 1;
  localparam int CCR_INT    = 2;
  // pwm control: double edge select [5:0], output enable [11:6]
  localparam int PCR_W      = 2 * NUM_PWM;
  localparam int PCR_OE     = NUM_PWM;
  // flag layout: matches [6:0], captures [10:7]
  localparam int FLAG_CAP   = NUM_MATCH;

  localparam logic [CTRL_W-1:0]          CTRL_RESET  = 6'h00;
  localparam logic [DATA_W-1:0]          COUNT_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0]          PRE_RESET   = 32'h0000_0000;
  localparam logic [NUM_MATCH*MCR_W-1:0] MCR_RESET   = 21'h00_0000;
  localparam logic [NUM_CAP*CCR_W-1:0]   CCR_RESET   = 12'h000;
  localparam logic [PCR_W-1:0]           PCR_RESET   = 12'h000;
endpackage

// ==== testbench/dual_edge_pwm_timer_chk.sv ====
// Purpose: port level checks for the pwm timer
// Assumes: pwm mode is mirrored from bus writes to the control word
// Notes:   bound into the design top
module pwm_timer_chk (
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [3:0]  cap_in,
  input wire logic [5:0]  pwm_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import pwm_timer_pkg::*;
  logic take;
  logic rd_ack;
  logic pwm_q;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd_ack = wb_ack_o && !wb_we_i;
  always_ff @(posedge core_clk) begin
    if (reset)
      pwm_q <= 1'h0;
    else if (take && wb_we_i && wb_sel_i[0] && wb_adr_i == OFF_CTRL)
      pwm_q <= wb_dat_i[CTRL_PWM];
  end
  ////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  a_ack_next: assert property (take |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(take))
    else $error("ack without request");
  a_reset_quiet: assert property (disable iff (1'h0) reset |=> !wb_ack_o && pwm_out == 6'h00)
    else $error("outputs active in reset");
  a_unmapped_zero: assert property (rd_ack && wb_adr_i == 8'h24 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_plain_timer: assert property (!pwm_q && !$past(pwm_q) |-> pwm_out == 6'h00)
    else $error("pwm output outside pwm mode");
  a_release_bits: assert property (rd_ack && wb_adr_i == OFF_RELEASE |-> wb_dat_o[31:7] == 25'h0)
    else $error("release readback too wide");
  a_flag_bits: assert property (rd_ack && wb_adr_i == OFF_FLAGS |-> wb_dat_o[31:11] == 21'h0)
    else $error("flag readback too wide");
  c_write: cover property (wb_ack_o && wb_we_i);
  c_pulse: cover property ($fell(pwm_out[0]));
  c_double: cover property (pwm_out[1] && !pwm_out[0]);
endmodule // pwm_timer_chk

bind dual_edge_pwm_timer pwm_timer_chk pwm_timer_chk_inst (.core_clk, .reset, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cap_in, .pwm_out);

// ==== testbench/pwm_load_model.sv ====
// Purpose: load stage on the pwm outputs, measures pulse high time
// Assumes: capture pins read the load sense of outputs zero to three
// Notes:   width holds 8 bits per output, last completed pulse
module pwm_load_model (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic [5:0]  pwm_out,
  output logic      [3:0]  cap_in,
  output logic      [47:0] width,
  output logic      [7:0]  rises
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] run [6];
  assign cap_in = pwm_out[3:0];
  always @(posedge core_clk) begin
    if (reset) begin
      run <= '{default: 8'h00};
      width <= 48'h0;
      rises <= 8'h00;
    end else begin
      for (int k = 0; k < 6; k++) begin
        run[k] <= pwm_out[k] ? run[k] + 8'h01 : 8'h00;
        if (!pwm_out[k] && run[k] != 8'h00)
          width[8*k +: 8] <= run[k];
      end
      if (pwm_out[0] && run[0] == 8'h00)
        rises <= rises + 8'h01;
    end
  end
endmodule // pwm_load_model

// ==== testbench/tb_dual_edge_pwm_timer.sv ====
// Purpose: register and waveform tests for the pwm timer
// Assumes: one bus access at a time, prescale 0 in pwm runs
// Notes:   pulse widths are counted by the load model
module tb_dual_edge_pwm_timer;
  timeunit 1ns;
  timeprecision 1ps;
  import pwm_timer_pkg::*;
  localparam logic [7:0] REGS [6] = '{OFF_CTRL, OFF_FLAGS, OFF_COUNT, OFF_MATCHCTL,
    OFF_PWMCTL, OFF_RELEASE};
  localparam logic [31:0] MVAL [7] = '{32'h9, 32'h4, 32'h7, 32'h2, 32'h0, 32'h6, 32'h2};
  localparam logic [31:0] WEXP [6] = '{32'h5, 32'h3, 32'h5, 32'h0, 32'h7, 32'h3};
  logic        core_clk = 1'h0;
  logic        reset    = 1'h1;
  logic        cyc      = 1'h0;
  logic        we       = 1'h0;
  logic [7:0]  adr      = 8'h00;
  logic [31:0] wdat     = 32'h0;
  logic [31:0] rdat;
  logic [31:0] got;
  logic        ack;
  logic [5:0]  pwm;
  logic [3:0]  cap;
  logic [47:0] width;
  logic [7:0]  rises;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          cycles    = 0;

  initial forever #2.5 core_clk = ~core_clk;

  dual_edge_pwm_timer dual_edge_pwm_timer_inst (.core_clk, .reset, .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .cap_in(cap), .pwm_out(pwm));
  pwm_load_model pwm_load_model_inst (.core_clk, .reset, .pwm_out(pwm), .cap_in(cap),
    .width, .rises);
  ////////////////////////////////////////////////////////////
  task automatic conclude();
    if (error_cnt == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // one classic cycle; ack and data are taken at the edge that samples ack high
  task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    cyc <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge core_clk); while (ack !== 1'h1);
    got = rdat;
    cyc <= 1'h0;
    we <= 1'h0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    access(1'h0, a, 32'h0);
    check(got & m, e);
  endtask

  task automatic periods(input int n);
    logic [7:0] s;
    s = rises;
    while (rises - s < 8'(n)) @(posedge core_clk);
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge core_clk);
    reset <= 1'h0;
    foreach (REGS[i]) rd_chk(REGS[i], 32'hFFFF_FFFF, 32'h0);
    access(1'h1, 8'h24, 32'hFFFF_FFFF);
    rd_chk(8'h24, 32'hFFFF_FFFF, 32'h0);
    // plain timer: match0 flags, resets and stops; match1 flags and continues
    access(1'h1, OFF_PRESCALE, 32'h1);
    access(1'h1, OFF_MATCH, 32'h9);
    access(1'h1, OFF_MATCH + 8'h04, 32'h3);
    access(1'h1, OFF_MATCHCTL, 32'hF);
    access(1'h1, OFF_CTRL, 32'h1);
    do access(1'h0, OFF_CTRL, 32'h0); while (got[0] !== 1'h0);
    rd_chk(OFF_FLAGS, 32'hFFFF_FFFF, 32'h3);
    rd_chk(OFF_COUNT, 32'hFFFF_FFFF, 32'h0);
    access(1'h1, OFF_FLAGS, 32'h1);
    rd_chk(OFF_FLAGS, 32'hFFFF_FFFF, 32'h2);
    access(1'h1, OFF_FLAGS, 32'h7FF);
    // pwm: outputs 1 and 2 double edge, the rest single edge
    access(1'h1, OFF_MATCHCTL, 32'h0);
    access(1'h1, OFF_PRESCALE, 32'h0);
    foreach (MVAL[i]) access(1'h1, OFF_MATCH + 8'(4 * i), MVAL[i]);
    access(1'h1, OFF_CAPCTL, 32'h5);
    access(1'h1, OFF_PWMCTL, 32'hFC6);
    access(1'h1, OFF_CTRL, 32'h5);
    periods(3);
    foreach (WEXP[k]) check(32'(width[8*k +: 8]), WEXP[k]);
    rd_chk(OFF_FLAGS, 32'hFFFF_FFFF, 32'h80);
    rd_chk(OFF_CAPTURE, 32'hFFFF_FFF0, 32'h0);
    // new match1 waits for its release
    access(1'h1, OFF_MATCH + 8'h04, 32'h2);
    periods(2);
    check(32'(width[7:0]), 32'h5);
    rd_chk(OFF_MATCH + 8'h04, 32'hFFFF_FFFF, 32'h2);
    access(1'h1, OFF_RELEASE, 32'h2);
    periods(3);
    check(32'(width[7:0]), 32'h3);
    check(32'(width[15:8]), 32'h5);
    rd_chk(OFF_RELEASE, 32'hFFFF_FFFF, 32'h0);
    access(1'h1, OFF_CTRL, 32'h1);
    rd_chk(OFF_CTRL, 32'h0000_0004, 32'h0);
    check({26'h0, pwm}, 32'h0);
    conclude();
  end
endmodule // tb_dual_edge_pwm_timer
